// ==== rtl/sddma_engine.sv ====
// Descriptor-driven DMA engine of an SD/MMC host: APB register slave,
// AHB master for descriptors and buffers, FIFO push/pop toward the card side.
// Assumes the bus interface unit gates its request so that a whole chunk
// of FIFO data or space is available when the request is high.
`timescale 1ns/100ps

module sddma_engine #(
  parameter int BURST_BEATS = 4
) (
  input wire logic i_clk,
  input wire logic i_reset,
  // APB register slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // AHB master
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [2:0] o_hburst,
  output logic [31:0] o_hwdata,
  input wire logic [31:0] i_hrdata,
  input wire logic i_hready,
  input wire logic i_hresp,
  // Bus interface unit side
  input wire logic i_biu_write_command,
  input wire logic i_command_done,
  input wire logic i_biu_error,
  input wire logic i_dma_transfer_request,
  output logic [11:0] o_transmit_threshold,
  output logic [11:0] o_receive_threshold,
  output logic o_fifo_push,
  output logic [31:0] o_fifo_wdata,
  output logic o_fifo_pop,
  input wire logic [31:0] i_fifo_rdata,
  output logic o_interrupt
);
  import sddma_pkg::*;

  localparam logic [12:0] BURST_BYTES = 13'(BURST_BEATS * 4);
  localparam logic [4:0] BURST_COUNT = 5'(BURST_BEATS);
  localparam logic [4:0] DESC_COUNT = 5'(DESC_WORDS);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [31:0] fifo_threshold_config;
  logic [31:0] bus_mode_config;
  logic [31:0] descriptor_list_base;
  logic [31:0] dma_interrupt_enable;
  logic [31:0] dma_event_status;
  logic [31:0] current_descriptor_pointer;
  logic [31:0] current_buffer_pointer;
  logic base_written;
  logic poll_pulse;
  logic normal_summary_flag;
  logic abnormal_summary_flag;
  logic [31:0] read_data;
  logic read_hit;
  logic apb_write;
  sddma_state_t state;
  logic [31:0] desc_word [DESC_WORDS];
  logic [1:0] word_idx;
  logic [12:0] remain;
  logic [12:0] chunk_bytes;
  logic [4:0] addr_left;
  logic [4:0] data_left;
  logic dphase;
  logic start_pending;
  logic cmd_ok;
  logic transmit_dir;
  logic ev_tx_done;
  logic ev_rx_done;
  logic ev_bus_error;
  logic ev_unavail;
  logic ev_card_error;
  logic op_done;
  logic [31:0] next_descriptor;
  logic [31:0] event_set;
  logic [31:0] event_clear;

  assign o_hsize = HSIZE_WORD;
  assign o_transmit_threshold = fifo_threshold_config[TX_THRESHOLD_LSB +: THRESHOLD_WIDTH];
  assign o_receive_threshold = fifo_threshold_config[RX_THRESHOLD_LSB +: THRESHOLD_WIDTH];
  assign apb_write = i_psel && i_penable && o_pready && i_pwrite;

  // ************************************************************
  // Register read decode
  // ************************************************************
  // Read mux; poll demand is write-only and reads as zero
  always_comb begin
    read_hit = 1'b1;
    read_data = RESET_WORD;
    unique case (i_paddr)
      OFF_FIFO_THRESHOLD: read_data = fifo_threshold_config;
      OFF_BUS_MODE: read_data = bus_mode_config;
      OFF_POLL_DEMAND: read_data = RESET_WORD;
      OFF_LIST_BASE: read_data = descriptor_list_base;
      OFF_EVENT_STATUS: begin
        read_data = dma_event_status;
        read_data[ST_NORMAL_SUMMARY] = normal_summary_flag;
        read_data[ST_ABNORMAL_SUMMARY] = abnormal_summary_flag;
      end
      OFF_IRQ_ENABLE: read_data = dma_interrupt_enable;
      OFF_CUR_DESC: read_data = current_descriptor_pointer;
      OFF_CUR_BUF: read_data = current_buffer_pointer;
      default: read_hit = 1'b0;
    endcase
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  // One wait-free access: ready rises in the access phase
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_prdata <= RESET_WORD;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !read_hit;
      if (i_psel && !i_penable && !i_pwrite) begin
        o_prdata <= read_data;
      end
    end
  end

  // Software-written configuration and the strobes derived from it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fifo_threshold_config <= RESET_WORD;
      bus_mode_config <= RESET_WORD;
      descriptor_list_base <= RESET_WORD;
      dma_interrupt_enable <= RESET_WORD;
      base_written <= 1'b0;
      poll_pulse <= 1'b0;
    end else begin
      base_written <= apb_write && (i_paddr == OFF_LIST_BASE);
      poll_pulse <= apb_write && (i_paddr == OFF_POLL_DEMAND);
      if (apb_write) begin
        unique case (i_paddr)
          OFF_FIFO_THRESHOLD: fifo_threshold_config <= i_pwdata & FIFO_THRESHOLD_MASK;
          OFF_BUS_MODE: bus_mode_config <= i_pwdata & BUS_MODE_MASK;
          OFF_LIST_BASE: descriptor_list_base <= i_pwdata;
          OFF_IRQ_ENABLE: dma_interrupt_enable <= i_pwdata & ENABLE_MASK;
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // Status and interrupt
  // ************************************************************
  assign event_clear = (apb_write && (i_paddr == OFF_EVENT_STATUS)) ?
                       (i_pwdata & EVENT_MASK) : RESET_WORD;
  assign event_set = {26'h0000000, ev_card_error, ev_unavail, 1'b0,
                      ev_bus_error, ev_rx_done, ev_tx_done};

  // Sticky flags; a set in the clearing cycle wins, nothing is counted
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dma_event_status <= RESET_WORD;
    end else begin
      dma_event_status <= (dma_event_status & ~event_clear) | event_set;
    end
  end

  // Summaries follow the enabled flags, so they fall on their own
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      normal_summary_flag <= 1'b0;
      abnormal_summary_flag <= 1'b0;
      o_interrupt <= 1'b0;
    end else begin
      normal_summary_flag <= |(dma_event_status & dma_interrupt_enable & NORMAL_MASK);
      abnormal_summary_flag <= |(dma_event_status & dma_interrupt_enable & ABNORMAL_MASK);
      o_interrupt <= normal_summary_flag || abnormal_summary_flag;
    end
  end

  // ************************************************************
  // Engine and AHB master
  // ************************************************************
  assign op_done = dphase && i_hready && !i_hresp && (data_left == 5'h01);
  assign chunk_bytes = (remain >= BURST_BYTES) ? BURST_BYTES : 13'h0004;

  // Next descriptor: ring wrap first, then chained pointer, then stride
  always_comb begin
    if (desc_word[0][DESC_END_OF_RING_BIT]) begin
      next_descriptor = descriptor_list_base;
    end else if (desc_word[0][DESC_CHAINED_BIT]) begin
      next_descriptor = desc_word[3];
    end else begin
      next_descriptor = current_descriptor_pointer + DESC_STRIDE;
    end
  end

  // Buffer bursts use undefined-length INCR (descriptor fetches use INCR4) so no 1 KB check is made; buffers
  // that straddle such a boundary are the driver's concern.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= SDDMA_IDLE;
      for (int i = 0; i < DESC_WORDS; i++) begin
        desc_word[i] <= RESET_WORD;
      end
      word_idx <= 2'h0;
      remain <= 13'h0000;
      addr_left <= 5'h00;
      data_left <= 5'h00;
      dphase <= 1'b0;
      start_pending <= 1'b0;
      cmd_ok <= 1'b0;
      transmit_dir <= 1'b0;
      current_descriptor_pointer <= RESET_WORD;
      current_buffer_pointer <= RESET_WORD;
      o_haddr <= RESET_WORD;
      o_htrans <= HTRANS_IDLE;
      o_hwrite <= 1'b0;
      o_hburst <= HBURST_SINGLE;
      o_hwdata <= RESET_WORD;
      o_fifo_push <= 1'b0;
      o_fifo_wdata <= RESET_WORD;
      o_fifo_pop <= 1'b0;
      ev_tx_done <= 1'b0;
      ev_rx_done <= 1'b0;
      ev_bus_error <= 1'b0;
      ev_unavail <= 1'b0;
      ev_card_error <= 1'b0;
    end else begin
      ev_tx_done <= 1'b0;
      ev_rx_done <= 1'b0;
      ev_bus_error <= 1'b0;
      ev_unavail <= 1'b0;
      ev_card_error <= 1'b0;
      o_fifo_push <= 1'b0;
      o_fifo_pop <= 1'b0;
      if (base_written) begin
        start_pending <= 1'b1;
        current_descriptor_pointer <= descriptor_list_base;
      end
      // Pipelined beats: address phase and previous data phase overlap
      if (dphase && i_hresp) begin
        o_htrans <= HTRANS_IDLE;
        dphase <= 1'b0;
        addr_left <= 5'h00;
        data_left <= 5'h00;
        ev_bus_error <= 1'b1;
        state <= SDDMA_IDLE;
      end else if (i_hready && (dphase || o_htrans != HTRANS_IDLE)) begin
        if (dphase) begin
          data_left <= data_left - 5'h01;
          if (state == SDDMA_FETCH) begin
            desc_word[word_idx] <= i_hrdata;
            word_idx <= word_idx + 2'h1;
          end else if (state == SDDMA_XFER && !o_hwrite) begin
            o_fifo_wdata <= i_hrdata;
            o_fifo_push <= 1'b1;
          end
        end
        dphase <= (o_htrans != HTRANS_IDLE);
        if (o_htrans != HTRANS_IDLE) begin
          if (o_hwrite && state == SDDMA_XFER) begin
            o_hwdata <= i_fifo_rdata;
            o_fifo_pop <= 1'b1;
          end else if (o_hwrite) begin
            o_hwdata <= desc_word[0] & ~(32'h1 << DESC_OWN_BIT);
          end
          if (addr_left > 5'h01) begin
            o_haddr <= o_haddr + WORD_STEP;
            o_htrans <= HTRANS_SEQ;
            addr_left <= addr_left - 5'h01;
          end else begin
            o_htrans <= HTRANS_IDLE;
            addr_left <= 5'h00;
          end
        end
      end
      unique case (state)
        SDDMA_IDLE: begin
          cmd_ok <= 1'b0;
          if (start_pending && bus_mode_config[BUS_MODE_ENABLE_BIT]) begin
            start_pending <= 1'b0;
            state <= SDDMA_LOAD;
          end
        end
        SDDMA_LOAD: begin
          o_haddr <= current_descriptor_pointer;
          o_htrans <= HTRANS_NONSEQ;
          o_hwrite <= 1'b0;
          o_hburst <= HBURST_INCR4;
          addr_left <= DESC_COUNT;
          data_left <= DESC_COUNT;
          word_idx <= 2'h0;
          state <= SDDMA_FETCH;
        end
        SDDMA_FETCH: begin
          if (op_done) begin
            state <= SDDMA_CHECK;
          end
        end
        SDDMA_CHECK: begin
          if (!desc_word[0][DESC_OWN_BIT]) begin
            ev_unavail <= 1'b1;
            state <= SDDMA_SUSPEND;
          end else begin
            remain <= desc_word[1][BUFFER_SIZE_MSB:0];
            current_buffer_pointer <= desc_word[2];
            state <= cmd_ok ? SDDMA_WAIT_REQ : SDDMA_WAIT_CMD;
          end
        end
        SDDMA_SUSPEND: begin
          if (poll_pulse) begin
            state <= SDDMA_LOAD;
          end
        end
        SDDMA_WAIT_CMD: begin
          if (i_biu_error) begin
            ev_card_error <= 1'b1;
            state <= SDDMA_IDLE;
          end else if (i_command_done) begin
            cmd_ok <= 1'b1;
            transmit_dir <= i_biu_write_command;
            state <= SDDMA_WAIT_REQ;
          end
        end
        SDDMA_WAIT_REQ: begin
          if (remain == 13'h0000) begin
            o_haddr <= current_descriptor_pointer;
            o_htrans <= HTRANS_NONSEQ;
            o_hwrite <= 1'b1;
            o_hburst <= HBURST_SINGLE;
            addr_left <= 5'h01;
            data_left <= 5'h01;
            state <= SDDMA_CLOSE;
          end else if (i_dma_transfer_request) begin
            o_haddr <= current_buffer_pointer;
            o_htrans <= HTRANS_NONSEQ;
            o_hwrite <= !transmit_dir;
            o_hburst <= (remain >= BURST_BYTES) ? HBURST_INCR : HBURST_SINGLE;
            addr_left <= (remain >= BURST_BYTES) ? BURST_COUNT : 5'h01;
            data_left <= (remain >= BURST_BYTES) ? BURST_COUNT : 5'h01;
            state <= SDDMA_XFER;
          end
        end
        SDDMA_XFER: begin
          if (op_done) begin
            current_buffer_pointer <= current_buffer_pointer + {19'h00000, chunk_bytes};
            remain <= remain - chunk_bytes;
            state <= SDDMA_WAIT_REQ;
          end
        end
        SDDMA_CLOSE: begin
          if (op_done) begin
            if (!desc_word[0][DESC_IRQ_SUPPRESS_BIT]) begin
              ev_tx_done <= transmit_dir;
              ev_rx_done <= !transmit_dir;
            end
            if (desc_word[0][DESC_LAST_BIT]) begin
              state <= SDDMA_IDLE;
            end else begin
              current_descriptor_pointer <= next_descriptor;
              state <= SDDMA_LOAD;
            end
          end
        end
        // Unused codes of the wider state word fall back to idle
        default: state <= SDDMA_IDLE;
      endcase
    end
  end

endmodule

// ==== rtl/sddma_pkg.sv ====
// Constants shared by the descriptor DMA engine: register map, descriptor
// fields, status layout and AHB encodings.
// Assumes word-aligned APB accesses and a 32-bit AHB data path.
package sddma_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] OFF_FIFO_THRESHOLD = 12'h04c;
  localparam logic [11:0] OFF_BUS_MODE = 12'h080;
  localparam logic [11:0] OFF_POLL_DEMAND = 12'h084;
  localparam logic [11:0] OFF_LIST_BASE = 12'h088;
  localparam logic [11:0] OFF_EVENT_STATUS = 12'h08c;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h090;
  localparam logic [11:0] OFF_CUR_DESC = 12'h094;
  localparam logic [11:0] OFF_CUR_BUF = 12'h098;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [11:0] RESET_THRESHOLD = 12'h000;

  // ************************************************************
  // Register fields
  // ************************************************************
  localparam int BUS_MODE_ENABLE_BIT = 7;
  localparam int TX_THRESHOLD_LSB = 0;
  localparam int RX_THRESHOLD_LSB = 16;
  localparam int THRESHOLD_WIDTH = 12;
  localparam logic [31:0] BUS_MODE_MASK = 32'h0000_0080;
  localparam logic [31:0] FIFO_THRESHOLD_MASK = 32'h0fff_0fff;

  // Status bit positions
  localparam int ST_TX_DONE = 0;
  localparam int ST_RX_DONE = 1;
  localparam int ST_BUS_ERROR = 2;
  localparam int ST_DESC_UNAVAIL = 4;
  localparam int ST_CARD_ERROR = 5;
  localparam int ST_NORMAL_SUMMARY = 8;
  localparam int ST_ABNORMAL_SUMMARY = 9;
  localparam logic [31:0] EVENT_MASK = 32'h0000_0037;
  localparam logic [31:0] NORMAL_MASK = 32'h0000_0003;
  localparam logic [31:0] ABNORMAL_MASK = 32'h0000_0034;
  localparam logic [31:0] ENABLE_MASK = 32'h0000_0037;

  // ************************************************************
  // Descriptor fields
  // ************************************************************
  localparam int DESC_OWN_BIT = 31;
  localparam int DESC_END_OF_RING_BIT = 5;
  localparam int DESC_CHAINED_BIT = 4;
  localparam int DESC_LAST_BIT = 2;
  localparam int DESC_IRQ_SUPPRESS_BIT = 1;
  localparam int BUFFER_SIZE_MSB = 12;
  localparam int DESC_WORDS = 4;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  // ************************************************************
  // AHB encodings
  // ************************************************************
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_INCR = 3'h1;
  localparam logic [2:0] HBURST_INCR4 = 3'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Engine states
  typedef enum logic [3:0] {
    SDDMA_IDLE,
    SDDMA_LOAD,
    SDDMA_FETCH,
    SDDMA_CHECK,
    SDDMA_SUSPEND,
    SDDMA_WAIT_CMD,
    SDDMA_WAIT_REQ,
    SDDMA_XFER,
    SDDMA_CLOSE
  } sddma_state_t;

endpackage

// ==== verification/sddma_mem_model.sv ====
// AHB memory on the engine's master side: 64 words, optional wait states.
// Assumes word accesses; the bench preloads and inspects mem directly.
`timescale 1ns/100ps
module sddma_mem_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_slow,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hready
);
  logic [31:0] mem [0:63];
  logic [5:0] addr;
  logic live;
  logic wr;
  logic tick;
  // Address phase is taken only with ready, data phase follows
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      live <= 1'b0;
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      if (o_hready) begin
        if (live && wr) mem[addr] <= i_hwdata;
        live <= i_htrans[1];
        wr <= i_hwrite;
        addr <= i_haddr[7:2];
      end
    end
  end
  // Slow mode stretches every other cycle; idle bus shows inverted data
  assign o_hready = !i_slow || tick;
  assign o_hrdata = (live && !wr) ? mem[addr] : ~mem[addr];
endmodule

// ==== verification/sddma_chk.sv ====
// Port-level assertions for the descriptor DMA engine.
// Assumes a single clock domain with async active-high reset.
`timescale 1ns/100ps
module sddma_chk (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_haddr,
  input wire logic [1:0] o_htrans,
  input wire logic [2:0] o_hburst,
  input wire logic [31:0] o_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  input wire logic o_fifo_push,
  input wire logic [31:0] o_fifo_wdata,
  input wire logic o_fifo_pop,
  input wire logic [31:0] i_fifo_rdata,
  input wire logic [11:0] o_transmit_threshold,
  input wire logic [11:0] o_receive_threshold,
  input wire logic o_interrupt
);
  import sddma_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ****************
  // APB side
  // ****************
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable && o_pready;
  endsequence
  property p_pready;
    s_setup |=> o_pready;
  endproperty
  a_pready: assert property (p_pready) else $error("no ready in access phase");
  property p_slverr;
    s_setup ##0 (i_paddr == 12'h0fc) |=> o_pslverr && o_prdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
  property p_poll_reads_zero;
    s_setup ##0 (!i_pwrite && i_paddr == OFF_POLL_DEMAND) |=> o_prdata == 32'h0;
  endproperty
  a_poll_reads_zero: assert property (p_poll_reads_zero) else $error("poll read");
  property p_threshold;
    s_access ##0 (i_pwrite && i_paddr == OFF_FIFO_THRESHOLD) |=>
      o_transmit_threshold == $past(i_pwdata[11:0]) &&
      o_receive_threshold == $past(i_pwdata[27:16]);
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold fields");
  // Interrupt follows the summary bits that a status read returns
  property p_irq;
    s_access ##0 (!i_pwrite && i_paddr == OFF_EVENT_STATUS) |->
      o_interrupt == (o_prdata[8] | o_prdata[9]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt vs summary");
  // ****************
  // AHB and FIFO side
  // ****************
  property p_hold;
    o_htrans[1] && !i_hready |=> $stable(o_haddr) && $stable(o_htrans);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed while stalled");
  property p_seq_burst;
    o_htrans == HTRANS_SEQ |-> o_hburst != HBURST_SINGLE;
  endproperty
  a_seq_burst: assert property (p_seq_burst) else $error("sequential beat in single");
  property p_push;
    o_fifo_push |-> o_fifo_wdata == $past(i_hrdata);
  endproperty
  a_push: assert property (p_push) else $error("pushed word not read data");
  property p_pop;
    o_fifo_pop |-> o_hwdata == $past(i_fifo_rdata);
  endproperty
  a_pop: assert property (p_pop) else $error("popped word not on write data");
endmodule
bind sddma_engine sddma_chk i_sddma_chk (.*);

// ==== verification/tb_top.sv ====
// Self-checking bench: APB stimulus, memory model, FIFO stand-in.
// Assumes the engine with default burst length and a 20 MHz clock.
`timescale 1ns/100ps
module tb_top;
  import sddma_pkg::*;
  logic i_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, o_haddr, o_hwdata, i_hrdata, o_fifo_wdata, rd;
  logic [31:0] i_fifo_rdata = 32'ha5a5_0000;
  logic o_pready, o_pslverr, o_hwrite, i_hready, i_hresp = 0, o_fifo_push, o_fifo_pop;
  logic i_biu_write_command = 0, i_command_done = 0, i_biu_error = 0;
  logic i_dma_transfer_request = 0, o_interrupt, slow = 0;
  logic [1:0] o_htrans;
  logic [2:0] o_hsize, o_hburst;
  logic [11:0] o_transmit_threshold, o_receive_threshold;
  int error_cnt = 0, compares = 0, pushes = 0, pops = 0, singles = 0;
  sddma_engine i_sddma_engine (.*);
  sddma_mem_model i_sddma_mem_model (.i_clk(i_clk), .i_reset(i_reset), .i_slow(slow),
    .i_haddr(o_haddr), .i_htrans(o_htrans), .i_hwrite(o_hwrite), .i_hwdata(o_hwdata),
    .o_hrdata(i_hrdata), .o_hready(i_hready));
  // Clock at 50 ns period
  always #25 i_clk = ~i_clk;
  // FIFO stand-in: check pushes, advance head on pop, count single beats
  always @(posedge i_clk) begin
    if (o_fifo_push === 1'b1) begin
      chk("push data", i_sddma_mem_model.mem[16 + pushes], o_fifo_wdata);
      pushes++;
    end
    if (o_fifo_pop === 1'b1) begin
      pops++;
      i_fifo_rdata <= i_fifo_rdata + 32'h1;
    end
    if (o_htrans === HTRANS_NONSEQ && o_hburst === HBURST_SINGLE && i_hready) singles++;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic step;
    @(posedge i_clk);
    #2;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB cycle; read data lands in rd
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    step;
    i_psel = 1;
    i_pwrite = wr;
    i_paddr = a;
    i_pwdata = d;
    step;
    i_penable = 1;
    step;
    rd = o_prdata;
    i_psel = 0;
    i_penable = 0;
  endtask
  task automatic wait_st(logic [31:0] m);
    for (int n = 0; n < 300; n++) begin
      apb(0, OFF_EVENT_STATUS, 0);
      if ((rd & m) !== 32'h0) return;
    end
    chk("status wait", m, rd);
    tally_and_finish;
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    logic [11:0] offs [7] = '{12'h04c, 12'h080, 12'h088, 12'h08c, 12'h090, 12'h094, 12'h098};
    foreach (offs[i]) begin
      apb(0, offs[i], 0);
      chk("reset value", RESET_WORD, rd);
    end
    apb(0, 12'h0fc, 0);
    apb(0, OFF_POLL_DEMAND, 0);
    chk("poll demand read", RESET_WORD, rd);
    apb(1, OFF_FIFO_THRESHOLD, 32'hffff_ffff);
    apb(0, OFF_FIFO_THRESHOLD, 0);
    chk("threshold", FIFO_THRESHOLD_MASK, rd);
  endtask
  // Transmit of 20 bytes: one burst plus one single, gated by command done
  task automatic t_tx;
    i_sddma_mem_model.mem[0] = 32'h8000_0004;
    i_sddma_mem_model.mem[1] = 32'd20;
    i_sddma_mem_model.mem[2] = 32'h40;
    for (int i = 0; i < 5; i++) i_sddma_mem_model.mem[16 + i] = 32'h1357_0000 + 32'(i * 3);
    i_biu_write_command = 1;
    i_dma_transfer_request = 1;
    apb(1, OFF_FIFO_THRESHOLD, 32'h0008_0004);
    apb(1, OFF_BUS_MODE, BUS_MODE_MASK);
    apb(1, OFF_IRQ_ENABLE, ENABLE_MASK);
    apb(1, OFF_LIST_BASE, 32'h0);
    repeat (20) step;
    chk("pushes before done", 0, 32'(pushes));
    i_biu_error = 1;
    wait_st(32'h20);
    i_biu_error = 0;
    apb(0, OFF_EVENT_STATUS, 0);
    chk("card error status", 32'h220, rd);
    apb(1, OFF_EVENT_STATUS, 32'h20);
    apb(1, OFF_LIST_BASE, 32'h0);
    repeat (20) step;
    chk("pushes after error", 0, 32'(pushes));
    i_command_done = 1;
    wait_st(32'h1);
    chk("push count", 5, 32'(pushes));
    chk("single beats", 2, 32'(singles));
    chk("tx word0 back", 32'h0000_0004, i_sddma_mem_model.mem[0]);
    apb(0, OFF_EVENT_STATUS, 0);
    chk("tx status", 32'h101, rd);
    chk("irq high", 1, {31'h0, o_interrupt});
    apb(1, OFF_EVENT_STATUS, 32'h1);
    apb(0, OFF_EVENT_STATUS, 0);
    chk("cleared status", 0, rd);
    chk("irq low", 0, {31'h0, o_interrupt});
  endtask
  // Receive over two chained descriptors, first one not yet owned
  task automatic t_rx;
    slow = 1;
    i_biu_write_command = 0;
    i_dma_transfer_request = 0;
    i_sddma_mem_model.mem[4] = 32'h0000_0010;
    i_sddma_mem_model.mem[5] = 32'd4;
    i_sddma_mem_model.mem[6] = 32'h80;
    i_sddma_mem_model.mem[7] = 32'h20;
    i_sddma_mem_model.mem[8] = 32'h8000_0020;
    i_sddma_mem_model.mem[9] = 32'd4;
    i_sddma_mem_model.mem[10] = 32'h90;
    apb(1, OFF_LIST_BASE, 32'h10);
    wait_st(32'h10);
    apb(0, OFF_EVENT_STATUS, 0);
    chk("unavailable status", 32'h210, rd);
    apb(1, OFF_EVENT_STATUS, 32'h10);
    i_sddma_mem_model.mem[4] = 32'h8000_0010;
    apb(1, OFF_POLL_DEMAND, 32'h5a);
    repeat (30) step;
    chk("pops without request", 0, 32'(pops));
    i_dma_transfer_request = 1;
    for (int n = 0; n < 300 && i_sddma_mem_model.mem[8][31] !== 1'b0; n++) step;
    chk("rx word0 A", 32'h0000_0010, i_sddma_mem_model.mem[4]);
    chk("rx word0 B", 32'h0000_0020, i_sddma_mem_model.mem[8]);
    if (i_sddma_mem_model.mem[8][31] !== 1'b0) tally_and_finish;
    chk("rx data A", 32'ha5a5_0000, i_sddma_mem_model.mem[32]);
    chk("rx data B", 32'ha5a5_0001, i_sddma_mem_model.mem[36]);
    // Ring wrap refetches the first descriptor, now host-owned again
    repeat (20) step;
    apb(0, OFF_EVENT_STATUS, 0);
    chk("rx status", 32'h312, rd);
    apb(0, OFF_CUR_DESC, 0);
    chk("current descriptor", 32'h0000_0010, rd);
    apb(0, OFF_CUR_BUF, 0);
    chk("current buffer", 32'h0000_0094, rd);
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    #2 i_reset = 0;
    t_regs;
    t_tx;
    t_rx;
    tally_and_finish;
  end
endmodule
